/* hdl/core_ctl_pkg.sv */
package core_ctl_pkg;

  localparam int unsigned WORD_BITS  = 36;
  localparam int unsigned ADDR_BITS  = 10;
  localparam int unsigned PTR_BITS   = 15;
  localparam int unsigned HALF_BITS  = 5;
  localparam int unsigned LINE_COUNT = 32;
  localparam int unsigned GROUP_CNT  = 4;
  localparam int unsigned TIMED_CNT  = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_PTR    = 8'h04;
  localparam logic [7:0] OFF_WORD_L = 8'h08;
  localparam logic [7:0] OFF_WORD_H = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_HOLD_L = 8'h14;
  localparam logic [7:0] OFF_HOLD_H = 8'h18;
  localparam logic [7:0] OFF_REFCNT = 8'h1c;

  // Status field positions
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_MON_BIT   = 1;
  localparam int unsigned ST_CNT_LSB   = 4;
  localparam int unsigned ST_CMD_LSB   = 8;
  localparam int unsigned ST_LATCH_LSB = 16;

  // Command encodings in CMD[1:0]
  localparam logic [1:0] CMD_READ  = 2'h0;
  localparam logic [1:0] CMD_FULL  = 2'h1;
  localparam logic [1:0] CMD_LOW   = 2'h2;
  localparam logic [1:0] CMD_MID   = 2'h3;

  // Stages that write for each request
  localparam logic [35:0] MASK_NONE = 36'h0_0000_0000;
  localparam logic [35:0] MASK_LOW  = 36'h0_0000_7fff;
  localparam logic [35:0] MASK_MID  = 36'h0_3fff_8000;
  localparam logic [35:0] MASK_ALL  = 36'hf_ffff_ffff;

  // Reset values
  localparam logic [35:0] WORD_RST  = 36'h0_0000_0000;
  localparam logic [14:0] PTR_RST   = 15'h0000;
  localparam logic [9:0]  LATCH_RST = 10'h000;

  // Pulse counter codes
  localparam logic [2:0] CNT_IDLE = 3'h0;
  localparam logic [2:0] CNT_ONE  = 3'h1;
  localparam logic [2:0] CNT_TWO  = 3'h2;
  localparam logic [2:0] CNT_THR  = 3'h3;
  localparam logic [2:0] CNT_FOUR = 3'h4;
  localparam logic [2:0] CNT_FIVE = 3'h5;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned DISTURB_NS    = 2000;
  localparam int unsigned PULSE_GAP_NS  = 2000;
  localparam int unsigned DISTURB_CYC   = DISTURB_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_GAP_CYC = PULSE_GAP_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  DISTURB_LOAD  = 6'(DISTURB_CYC - 1);
  localparam logic [5:0]  GAP_LOAD      = 6'(PULSE_GAP_CYC - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_TAIL
  } seq_state_e;

endpackage : core_ctl_pkg

/* hdl/line_select_decoder.sv */
`timescale 1ns/1ps
module line_select_decoder
  import core_ctl_pkg::*;
(
  input  wire logic [4:0]  sel,
  input  wire logic        rd_en,
  input  wire logic        wr_en,
  input  wire logic        rd_pulse,
  input  wire logic        wr_pulse,
  output logic      [3:0]  rd_group,
  output logic      [7:0]  rd_timed,
  output logic      [3:0]  wr_group,
  output logic      [7:0]  wr_timed,
  output logic      [31:0] rd_line,
  output logic      [31:0] wr_line
);

  // Group from the two upper select bits, timed pulse from the three lower
  genvar g;
  generate
    for (g = 0; g < GROUP_CNT; g++) begin : g_grp
      assign rd_group[g] = rd_en & (sel[4:3] == 2'(g));
      assign wr_group[g] = wr_en & (sel[4:3] == 2'(g));
    end
    for (g = 0; g < TIMED_CNT; g++) begin : g_tim
      assign rd_timed[g] = rd_pulse & (sel[2:0] == 3'(g));
      assign wr_timed[g] = wr_pulse & (sel[2:0] == 3'(g));
    end
    // Coincidence of group and timed pulse picks the driver
    for (g = 0; g < LINE_COUNT; g++) begin : g_line
      assign rd_line[g] = rd_group[g / 8] & rd_timed[g % 8];
      assign wr_line[g] = wr_group[g / 8] & wr_timed[g % 8];
    end
  endgenerate

endmodule : line_select_decoder

/* hdl/core_array_address_and_digit_control.sv */
`timescale 1ns/1ps
// Functional notes
// - one-bits get only the trailing two-microsecond disturb
// - sense counts only in read step one
// - thirty-six bit planes share one selection
// - copy low ten pointer bits per reference
// - X from bits 0-4, Y from 5-9
// - bits 3,4 with read enable: one group
// - bits 0-2 with read pulse: one timed pulse
// - one X line where group and pulse coincide
// - bits 5-9 decode one Y line alike
// - each address picks one core per plane
// - step two uses write enable, same lines
// - thirty-six stage hold register, one per plane
// - first timing pulse clears all hold stages
// - partial write: others restore, no transfer
// - request picks low, middle or all stages
// - write pulse gated by word bit sets stage
// - disturb only with window and disturb enable
// - zero bits inhibited before, until two microseconds after
// - zero stage gates window onto inhibit line
// - three-bit counter emits pulses one to five
// - read enable 0-3, write 3-5, pulses 2,4
module core_array_address_and_digit_control
  import core_ctl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [35:0] sense_in,
  output logic      [3:0]  x_read_group,
  output logic      [7:0]  x_read_timed,
  output logic      [3:0]  x_write_group,
  output logic      [7:0]  x_write_timed,
  output logic      [31:0] x_read_line,
  output logic      [31:0] x_write_line,
  output logic      [3:0]  y_read_group,
  output logic      [7:0]  y_read_timed,
  output logic      [3:0]  y_write_group,
  output logic      [7:0]  y_write_timed,
  output logic      [31:0] y_read_line,
  output logic      [31:0] y_write_line,
  output logic      [35:0] inhibit_line,
  output logic             seq_busy
);

  seq_state_e  state_q;
  logic [5:0]  gap_q;
  logic [2:0]  core_pulse_counter_q;
  logic [1:0]  cmd_q;
  logic [14:0] storage_location_pointer_q;
  logic [9:0]  core_location_latch_q;
  logic [35:0] word_q;
  logic [35:0] bit_hold_stage_q;
  logic [35:0] sense_meta_q;
  logic [35:0] sense_sync_q;
  logic [1:0]  read_pulse_dly_q;
  logic [31:0] ref_count_q;
  logic        read_en_q;
  logic        write_en_q;
  logic        read_pulse_q;
  logic        write_pulse_q;
  logic        window_q;
  logic        disturb_q;
  logic        monitor_q;

  logic        acc_wr;
  logic        addr_ok;
  logic        idle;
  logic        start;
  logic        tick;
  logic        mcp1;
  logic        mcp2;
  logic        mcp3;
  logic        mcp4;
  logic        mcp5;
  logic        mcp5_late;
  logic        is_read;
  logic [35:0] write_mask;
  logic [35:0] sense_take;

  // APB slave: always ready, one access phase per transfer
  assign pready  = 1'b1;
  assign acc_wr  = psel & penable & pwrite;
  assign idle    = (state_q == ST_IDLE);
  assign seq_busy = ~idle;

  always_comb begin
    unique case (paddr[7:0])
      OFF_CMD, OFF_PTR, OFF_WORD_L, OFF_WORD_H,
      OFF_STATUS, OFF_HOLD_L, OFF_HOLD_H, OFF_REFCNT: addr_ok = (paddr[31:8] == 24'h00_0000);
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_ok;

  // A command written while busy is dropped; the reference in flight must not be disturbed
  assign start = acc_wr & addr_ok & (paddr[7:0] == OFF_CMD) & idle;

  // Distributor pulses
  assign tick      = (state_q == ST_RUN) & (gap_q == 6'h00);
  assign mcp1      = tick & (core_pulse_counter_q == CNT_ONE);
  assign mcp2      = tick & (core_pulse_counter_q == CNT_TWO);
  assign mcp3      = tick & (core_pulse_counter_q == CNT_THR);
  assign mcp4      = tick & (core_pulse_counter_q == CNT_FOUR);
  assign mcp5      = tick & (core_pulse_counter_q == CNT_FIVE);
  assign mcp5_late = (state_q == ST_TAIL) & (gap_q == 6'h00);

  assign is_read = (cmd_q == CMD_READ);

  always_comb begin
    unique case (cmd_q)
      CMD_FULL: write_mask = MASK_ALL;
      CMD_LOW:  write_mask = MASK_LOW;
      CMD_MID:  write_mask = MASK_MID;
      CMD_READ: write_mask = MASK_NONE;
    endcase
  end

  // Sequencer state and pulse counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q              <= ST_IDLE;
      gap_q                <= 6'h00;
      core_pulse_counter_q <= CNT_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q              <= ST_RUN;
            gap_q                <= GAP_LOAD;
            core_pulse_counter_q <= CNT_ONE;
          end
        end
        ST_RUN: begin
          if (gap_q == 6'h00) begin
            if (core_pulse_counter_q == CNT_FIVE) begin
              core_pulse_counter_q <= CNT_IDLE;
              state_q              <= ST_TAIL;
              gap_q                <= DISTURB_LOAD;
            end else begin
              core_pulse_counter_q <= core_pulse_counter_q + 3'h1;
              gap_q                <= GAP_LOAD;
            end
          end else begin
            gap_q <= gap_q - 6'h01;
          end
        end
        ST_TAIL: begin
          if (gap_q == 6'h00) begin
            state_q <= ST_IDLE;
          end else begin
            gap_q <= gap_q - 6'h01;
          end
        end
      endcase
    end
  end

  // Request kind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= CMD_READ;
    end else if (start) begin
      cmd_q <= pwdata[1:0];
    end
  end

  // Pointer may change any time; the latch keeps the reference stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      storage_location_pointer_q <= PTR_RST;
    end else if (acc_wr && paddr[7:0] == OFF_PTR && addr_ok) begin
      storage_location_pointer_q <= pwdata[14:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_location_latch_q <= LATCH_RST;
    end else if (start) begin
      core_location_latch_q <= storage_location_pointer_q[9:0];
    end
  end

  // Read and write enables with their short pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_en_q <= 1'b0;
    end else if (start) begin
      read_en_q <= 1'b1;
    end else if (mcp3) begin
      read_en_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_en_q <= 1'b0;
    end else if (mcp3) begin
      write_en_q <= 1'b1;
    end else if (mcp5) begin
      write_en_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_pulse_q <= 1'b0;
    end else if (mcp2) begin
      read_pulse_q <= 1'b1;
    end else if (mcp3) begin
      read_pulse_q <= 1'b0;
    end
  end

  // Write pulse ends on the fifth pulse, which is where disturb begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_pulse_q <= 1'b0;
    end else if (mcp4) begin
      write_pulse_q <= 1'b1;
    end else if (mcp5) begin
      write_pulse_q <= 1'b0;
    end
  end

  // Inhibit-disturb window opens one pulse before the write pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_q <= 1'b0;
    end else if (mcp3) begin
      window_q <= 1'b1;
    end else if (mcp5_late) begin
      window_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disturb_q <= 1'b0;
    end else if (mcp5) begin
      disturb_q <= 1'b1;
    end else if (mcp5_late) begin
      disturb_q <= 1'b0;
    end
  end

  // Reference indicator, first to fifth pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_q <= 1'b0;
    end else if (mcp1) begin
      monitor_q <= 1'b1;
    end else if (mcp5) begin
      monitor_q <= 1'b0;
    end
  end

  // Sense amplifier outputs are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_meta_q <= WORD_RST;
      sense_sync_q <= WORD_RST;
    end else begin
      sense_meta_q <= sense_in;
      sense_sync_q <= sense_meta_q;
    end
  end

  // Sense lags the read pulse by the two sync stages; gate with an equally late pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_pulse_dly_q <= 2'h0;
    end else begin
      read_pulse_dly_q <= {read_pulse_dly_q[0], read_pulse_q};
    end
  end

  // Sense is taken only in the read step, and never by writing stages
  assign sense_take = {WORD_BITS{read_pulse_dly_q[1]}} & sense_sync_q & ~write_mask;

  // One hold stage per plane
  genvar b;
  generate
    for (b = 0; b < WORD_BITS; b++) begin : g_hold
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bit_hold_stage_q[b] <= 1'b0;
        end else if (mcp1) begin
          bit_hold_stage_q[b] <= 1'b0;
        end else if (mcp4 && write_mask[b] && word_q[b]) begin
          bit_hold_stage_q[b] <= 1'b1;
        end else if (sense_take[b]) begin
          bit_hold_stage_q[b] <= 1'b1;
        end
      end
    end
  endgenerate

  // Word register; software writes only while idle so no clash with sensing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= WORD_RST;
    end else if (acc_wr && addr_ok && idle && paddr[7:0] == OFF_WORD_L) begin
      word_q[31:0] <= pwdata;
    end else if (acc_wr && addr_ok && idle && paddr[7:0] == OFF_WORD_H) begin
      word_q[35:32] <= pwdata[3:0];
    end else if (mcp1 && is_read) begin
      word_q <= WORD_RST;
    end else if (is_read) begin
      word_q <= word_q | sense_take;
    end
  end

  // Completed references
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_count_q <= 32'h0000_0000;
    end else if (mcp5_late) begin
      ref_count_q <= ref_count_q + 32'h0000_0001;
    end
  end

  // Zero stages see the whole window, one stages only its disturb tail
  assign inhibit_line = {WORD_BITS{window_q}} &
                        (~bit_hold_stage_q | {WORD_BITS{disturb_q}});

  // X from the low half, Y from the high half of the latch
  line_select_decoder u_x_dec (
    .sel      (core_location_latch_q[4:0]),
    .rd_en    (read_en_q),
    .wr_en    (write_en_q),
    .rd_pulse (read_pulse_q),
    .wr_pulse (write_pulse_q),
    .rd_group (x_read_group),
    .rd_timed (x_read_timed),
    .wr_group (x_write_group),
    .wr_timed (x_write_timed),
    .rd_line  (x_read_line),
    .wr_line  (x_write_line)
  );

  line_select_decoder u_y_dec (
    .sel      (core_location_latch_q[9:5]),
    .rd_en    (read_en_q),
    .wr_en    (write_en_q),
    .rd_pulse (read_pulse_q),
    .wr_pulse (write_pulse_q),
    .rd_group (y_read_group),
    .rd_timed (y_read_timed),
    .wr_group (y_write_group),
    .wr_timed (y_write_timed),
    .rd_line  (y_read_line),
    .wr_line  (y_write_line)
  );

  // Read data, registered so it stands with the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr[7:0])
        OFF_CMD:    prdata <= {30'h0000_0000, cmd_q};
        OFF_PTR:    prdata <= {17'h0_0000, storage_location_pointer_q};
        OFF_WORD_L: prdata <= word_q[31:0];
        OFF_WORD_H: prdata <= {28'h000_0000, word_q[35:32]};
        OFF_STATUS: begin
          prdata                            <= 32'h0000_0000;
          prdata[ST_BUSY_BIT]               <= seq_busy;
          prdata[ST_MON_BIT]                <= monitor_q;
          prdata[ST_CNT_LSB +: 3]           <= core_pulse_counter_q;
          prdata[ST_CMD_LSB +: 2]           <= cmd_q;
          prdata[ST_LATCH_LSB +: ADDR_BITS] <= core_location_latch_q;
        end
        OFF_HOLD_L: prdata <= bit_hold_stage_q[31:0];
        OFF_HOLD_H: prdata <= {28'h000_0000, bit_hold_stage_q[35:32]};
        OFF_REFCNT: prdata <= ref_count_q;
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : core_array_address_and_digit_control

/* bench/core_ctl_checker.sv */
`timescale 1ns/1ps
module core_ctl_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [3:0]  x_read_group,
  input wire logic [7:0]  x_read_timed,
  input wire logic [3:0]  y_read_group,
  input wire logic [7:0]  y_read_timed,
  input wire logic [3:0]  x_write_group,
  input wire logic [7:0]  x_write_timed,
  input wire logic [3:0]  y_write_group,
  input wire logic [7:0]  y_write_timed,
  input wire logic [31:0] x_read_line,
  input wire logic [31:0] y_read_line,
  input wire logic [31:0] x_write_line,
  input wire logic [31:0] y_write_line,
  input wire logic [35:0] inhibit_line,
  input wire logic        seq_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] rd_x_q;
  logic [31:0] rd_y_q;
  logic [31:0] x_exp;
  // Write step must reuse the lines seen in the read step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_x_q <= '0;
      rd_y_q <= '0;
    end else if (|x_read_line) begin
      rd_x_q <= x_read_line;
      rd_y_q <= y_read_line;
    end
  end
  always_comb begin
    x_exp = '0;
    for (int i = 0; i < 32; i++) begin
      x_exp[i] = x_read_group[i/8] & x_read_timed[i%8];
    end
  end
  line_onehot_a: assert property ($onehot0(x_read_line) && $onehot0(x_write_line))
    else $error("more than one x line");
  line_and_a: assert property (x_read_line == x_exp)
    else $error("x line not group and pulse");
  group_one_a: assert property (|x_read_line |-> $onehot(x_read_group) && $onehot(x_read_timed))
    else $error("group or timed pulse not single");
  xy_pair_a: assert property ((|x_read_line) == (|y_read_line))
    else $error("x and y read lines disagree");
  y_group_a: assert property (|y_read_line |-> $onehot(y_read_group) && $onehot(y_read_timed))
    else $error("y group or timed pulse not single");
  wr_group_a: assert property (|y_write_line |-> $onehot(x_write_group) &&
    $onehot(x_write_timed) && $onehot(y_write_group) && $onehot(y_write_timed))
    else $error("write group or timed pulse not single");
  step_excl_a: assert property (!((|x_read_line) && (|x_write_line)))
    else $error("read and write lines overlap");
  same_lines_a: assert property (|x_write_line |-> x_write_line == rd_x_q && y_write_line == rd_y_q)
    else $error("write lines differ from read lines");
  lines_hold_a: assert property (|x_read_line && $past(|x_read_line) |-> $stable(x_read_line))
    else $error("read line moved in step");
  read_start_a: assert property ($rose(seq_busy) |-> ##[76:84] (|x_read_line))
    else $error("read step late");
  inh_before_a: assert property ($rose(|x_write_line) |-> (inhibit_line & ~$past(inhibit_line)) == 36'h0)
    else $error("inhibit not up before write");
  inh_steady_a: assert property (|x_write_line && $past(|x_write_line) |-> $stable(inhibit_line))
    else $error("inhibit moved in write step");
  disturb_len_a: assert property ($fell(|x_write_line) |-> (&inhibit_line)[*8] ##[30:34] !(|inhibit_line))
    else $error("disturb length wrong");
  inh_busy_a: assert property (|inhibit_line |-> seq_busy)
    else $error("inhibit outside sequence");
  cover property (|x_read_line);
  cover property (|x_write_line);
  cover property ($fell(seq_busy));
endmodule : core_ctl_checker

/* bench/core_matrix_stack_model.sv */
`timescale 1ns/1ps
module core_matrix_stack_model (
  input wire logic        pclk,
  input wire logic [31:0] x_read_line,
  input wire logic [31:0] y_read_line,
  input wire logic [31:0] x_write_line,
  input wire logic [31:0] y_write_line,
  input wire logic [35:0] inhibit_line,
  output logic     [35:0] sense_in
);
  logic [35:0] mem [1024];
  logic [35:0] noise_q;
  function automatic int idx(input logic [31:0] x, input logic [31:0] y);
    return $clog2(y) * 32 + $clog2(x);
  endfunction : idx
  initial begin
    foreach (mem[i]) mem[i] = '0;
    noise_q = 36'h5_a5a5_a5a5;
  end
  // Core goes to one unless its plane is inhibited
  always @(posedge pclk) begin
    noise_q <= ~noise_q;
    if (|x_write_line && |y_write_line) mem[idx(x_write_line, y_write_line)] <= ~inhibit_line;
  end
  // Sense line carries junk outside the read step
  assign sense_in = (|x_read_line && |y_read_line) ? mem[idx(x_read_line, y_read_line)] : noise_q;
endmodule : core_matrix_stack_model

/* bench/core_array_address_and_digit_control_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module core_array_address_and_digit_control_tb;
  import core_ctl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seq_busy, e;
  logic [31:0] paddr, pwdata, prdata, r, lf;
  logic [31:0] x_read_line, y_read_line, x_write_line, y_write_line;
  logic [35:0] sense_in, inhibit_line, d, m, w;
  logic [35:0] shadow [1024];
  logic [14:0] p;
  logic [1:0] c;
  int err_total, n_compared, cyc;
  core_array_address_and_digit_control u_core_array_address_and_digit_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sense_in, .x_read_group(), .x_read_timed(), .x_write_group(),
    .x_write_timed(), .x_read_line, .x_write_line, .y_read_group(), .y_read_timed(),
    .y_write_group(), .y_write_timed(), .y_read_line, .y_write_line, .inhibit_line,
    .seq_busy);
  core_matrix_stack_model u_core_matrix_stack_model (.pclk, .x_read_line, .y_read_line,
    .x_write_line, .y_write_line, .inhibit_line, .sense_in);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [35:0] wmask(input logic [1:0] k);
    return (k == 2'h2) ? 36'h0_0000_7fff : (k == 2'h3) ? 36'h0_3fff_8000 : 36'hf_ffff_ffff;
  endfunction : wmask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] dt);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_idle;
    do begin
      @(posedge pclk);
      #1;
    end while (seq_busy !== 1'b0);
    @(posedge pclk);
  endtask : wait_idle
  task automatic test_done;
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // A hung sequence must not stall the run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    lf = 32'd35786;
    foreach (shadow[i]) shadow[i] = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 32'h10, 32'h0);
    `CHK("status_rst", 32'h0, r)
    apb(1'b0, 32'h20, 32'h0);
    `CHK("unmapped_err", 1'b1, e)
    for (int k = 0; k < 14; k++) begin
      lf = nxt(lf);
      p = (k == 0) ? 15'h0000 : (k == 1) ? 15'h7fff : lf[14:0];
      lf = nxt(lf);
      d[31:0] = lf;
      lf = nxt(lf);
      d[35:32] = lf[3:0];
      c = 2'(k % 3 + 1);
      apb(1'b1, 32'h04, {17'h0, p});
      apb(1'b1, 32'h08, d[31:0]);
      apb(1'b1, 32'h0c, {28'h0, d[35:32]});
      apb(1'b1, 32'h00, {30'h0, c});
      wait_idle();
      apb(1'b0, 32'h10, 32'h0);
      `CHK("latch", p[9:0], r[25:16])
      `CHK("pulse_cnt", 3'h0, r[6:4])
      apb(1'b0, 32'h08, 32'h0);
      `CHK("word_kept", d[31:0], r)
      m = wmask(c);
      shadow[p[9:0]] = (shadow[p[9:0]] & ~m) | (d & m);
      apb(1'b1, 32'h00, 32'h0);
      wait_idle();
      apb(1'b0, 32'h08, 32'h0);
      w[31:0] = r;
      apb(1'b0, 32'h0c, 32'h0);
      w[35:32] = r[3:0];
      `CHK("read_word", shadow[p[9:0]], w)
      apb(1'b0, 32'h14, 32'h0);
      `CHK("hold_low", shadow[p[9:0]][31:0], r)
    end
    test_done();
  end
endmodule : core_array_address_and_digit_control_tb
bind core_array_address_and_digit_control core_ctl_checker u_core_ctl_checker (
  .pclk, .presetn, .x_read_group, .x_read_timed, .y_read_group, .y_read_timed,
  .x_write_group, .x_write_timed, .y_write_group, .y_write_timed, .x_read_line, .y_read_line,
  .x_write_line, .y_write_line, .inhibit_line, .seq_busy);
